/* File: cle_clamp_gen.sv */
// Internal clamp pulse generator: counts pixels from the hsync trailing edge
// Assumes hsync edge strobe is one pixel-clock pulse on the same clock
`include "cle_defines.svh"
module cle_clamp_gen
   import cle_pkg::*;
#(
   parameter int CNT_W = 13
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Line timing
   input  wire logic             trail_edge,
   input  wire logic [CNT_W-1:0] start_pixel,
   input  wire logic [7:0]       clamp_width,
   // Pulses
   output logic                  start_pulse,
   output logic                  restore_clamp
);
   cle_clamp_st_e    st_reg;
   cle_clamp_st_e    st_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [7:0]       wid_reg;
   logic [7:0]       wid_next;
   logic             start_reg;
   logic             start_next;
   logic             clamp_reg;
   logic             clamp_next;

   always_comb
   begin
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      wid_next   = wid_reg;
      start_next = 1'b0;
      clamp_next = 1'b0;
      case (st_reg)
         CLE_ST_IDLE:
         begin
         end
         CLE_ST_COUNT:
         begin
            if (cnt_reg == start_pixel)
            begin
               start_next = 1'b1;
               // Widths below two give a start strobe but no restore clamp
               if (clamp_width >= `CLE_MIN_CLAMP_WIDTH)
               begin
                  st_next    = CLE_ST_CLAMP;
                  clamp_next = 1'b1;
                  wid_next   = 8'h01;
               end
               else
                  st_next = CLE_ST_IDLE;
            end
            else
               cnt_next = cnt_reg + 1'b1;
         end
         CLE_ST_CLAMP:
         begin
            if (wid_reg == clamp_width)
               st_next = CLE_ST_IDLE;
            else
            begin
               clamp_next = 1'b1;
               wid_next   = wid_reg + 8'h01;
            end
         end
         default:
            st_next = CLE_ST_IDLE;
      endcase
      // A new line restarts the count and cuts off any restore clamp still running
      if (trail_edge)
      begin
         st_next    = CLE_ST_COUNT;
         cnt_next   = '0;
         clamp_next = 1'b0;
      end
      if (!ce)
      begin
         st_next    = st_reg;
         cnt_next   = cnt_reg;
         wid_next   = wid_reg;
         start_next = start_reg;
         clamp_next = clamp_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg    <= CLE_ST_IDLE;
         cnt_reg   <= '0;
         wid_reg   <= 8'h00;
         start_reg <= 1'b0;
         clamp_reg <= 1'b0;
      end
      else
      begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         wid_reg   <= wid_next;
         start_reg <= start_next;
         clamp_reg <= clamp_next;
      end
   end

   assign start_pulse   = start_reg;
   assign restore_clamp = clamp_reg;
endmodule : cle_clamp_gen

/* File: cle_defines.svh */
// Register offsets, field positions, reset values and timing constants
// Included by the clamp generator and top design files of the clamp and lock edge block
`ifndef CLE_DEFINES_SVH
`define CLE_DEFINES_SVH
`define CLE_ADDR_LOCK_PIN    8'h13
`define CLE_ADDR_START_HI    8'h14
`define CLE_ADDR_START_LO    8'h15
`define CLE_ADDR_CLAMP_WIDTH 8'h16
`define CLE_ADDR_DAC_CFG     8'h20
`define CLE_ADDR_STATUS      8'h21
`define CLE_ADDR_DAC_WRITE   8'h22
`define CLE_RST_LOCK_PIN     8'h04
`define CLE_RST_START_HI     8'h00
`define CLE_RST_START_LO     8'h03
`define CLE_RST_CLAMP_WIDTH  8'h10
`define CLE_RST_DAC_CFG      8'h00
`define CLE_BIT_LOCK_EDGE    0
`define CLE_BIT_PIN_DISABLE  3
`define CLE_FLD_FUNC_HI      5
`define CLE_FLD_FUNC_LO      4
`define CLE_BIT_DCR_EN       0
`define CLE_BIT_BLACK_DIS    1
`define CLE_START_HI_MSB     4
`define CLE_MIN_CLAMP_WIDTH  8'h02
`define CLE_SLOW_UPDATE_MS   100
`define CLE_CLK_MHZ          250
`define CLE_SLOW_UPDATE_CYC  (`CLE_SLOW_UPDATE_MS * 1000 * `CLE_CLK_MHZ)
`endif

/* File: cle_pkg.sv */
// Types shared by the clamp and lock edge block
// Assumes cle_defines.svh supplies the numeric constants
package cle_pkg;
   typedef enum logic [1:0]
   {
      CLE_FN_INVERT   = 2'h0,
      CLE_FN_CLAMP    = 2'h1,
      CLE_FN_COAST    = 2'h2,
      CLE_FN_EXT_PCLK = 2'h3
   } cle_pin_fn_e;
   typedef enum logic [2:0]
   {
      CLE_ST_IDLE  = 3'h1,
      CLE_ST_COUNT = 3'h2,
      CLE_ST_CLAMP = 3'h4
   } cle_clamp_st_e;
endpackage : cle_pkg

/* File: cle_sync.sv */
// Two-flop synchroniser for a pin input
// Assumes the pin is asynchronous to clk
module cle_sync
   import cle_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Data
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb
   begin
      meta_next = ce ? async_in : meta_reg;
      sync_next = ce ? meta_reg : sync_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule : cle_sync

/* File: cle_tb.sv */
// Self-checking bench for the clamp and lock edge block
// Assumes cle_video_src drives the sync pins and the checker is bound
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SYNC = 5;
   logic       clk, rst_n, ce, reg_wr, reg_rd, pin, go, vs, hsync_in, vsync_in;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       pll_lock_strobe, pll_coast, sample_clock_inversion, external_pixel_clock_sel;
   logic       dc_restore_clamp, auto_black_level_start, offset_dac_load;
   int         n_errors, comparisons, d, d0, bl, w, ld, lk;
   // Short slow-update count keeps the run brief
   cle_top #(.SLOW_CYC(50), .POST_LINES(2)) cle_top_inst
   (
      .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
      .vsync_in(vsync_in), .multi_purpose_input_pin(pin), .pll_lock_strobe(pll_lock_strobe),
      .pll_coast(pll_coast), .sample_clock_inversion(sample_clock_inversion),
      .external_pixel_clock_sel(external_pixel_clock_sel), .dc_restore_clamp(dc_restore_clamp),
      .auto_black_level_start(auto_black_level_start), .offset_dac_load(offset_dac_load)
   );
   cle_video_src #(.SYNC_LEN(SYNC)) cle_video_src_inst
   (
      .clk(clk), .go(go), .vs(vs), .hsync_in(hsync_in), .vsync_in(vsync_in)
   );
   task results;
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task chkb(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: level %b expected %b", $time, got, exp);
      end
   endtask : chkb
   task chkn(input int got, input int exp);
      comparisons++;
      if (got != exp)
      begin
         n_errors++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : chkn
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk8(reg_rdata, exp);
   endtask : rd
   // One line: counts strobes and clamp cycles, d is black start minus lock
   task line;
      int tl;
      int tk;
      lk = 0;
      bl = 0;
      w = 0;
      ld = 0;
      tl = 0;
      tk = 0;
      @(posedge clk);
      go <= 1'b1;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge clk);
         go <= 1'b0;
         #1;
         tl = (pll_lock_strobe === 1'b1) ? i : tl;
         tk = (auto_black_level_start === 1'b1) ? i : tk;
         lk += int'(pll_lock_strobe === 1'b1);
         bl += int'(auto_black_level_start === 1'b1);
         w += int'(dc_restore_clamp === 1'b1);
         ld += int'(offset_dac_load === 1'b1);
      end
      d = tk - tl;
   endtask : line
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (10000) @(posedge clk);
      n_errors++;
      results();
   end
   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pin = 1'b0;
      go = 1'b0;
      vs = 1'b0;
      n_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h13, 8'h04);
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h03);
      rd(8'h16, 8'h10);
      // Clock enable low must freeze the read data in place
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk8(reg_rdata, 8'h10);
      ce <= 1'b1;
      wr(8'h30, 8'hFF);
      rd(8'h30, 8'h00);
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'h1F);
      wr(8'h14, 8'h00);
      wr(8'h20, 8'h01);
      line;
      d0 = d;
      chkn(w, 16);
      chkn(bl, 1);
      chkn(ld, 1);
      wr(8'h15, 8'h08);
      line;
      chkn(d - d0, 5);
      wr(8'h16, 8'h02);
      line;
      chkn(w, 2);
      wr(8'h16, 8'h01);
      line;
      chkn(w, 0);
      chkn(ld, 1);
      wr(8'h16, 8'h00);
      line;
      chkn(w, 0);
      wr(8'h16, 8'h10);
      wr(8'h15, 8'h03);
      wr(8'h13, 8'h05);
      line;
      chkn(d - d0, SYNC);
      wr(8'h13, 8'h04);
      wr(8'h20, 8'h03);
      line;
      chkn(bl, 0);
      chkn(ld, 1);
      wr(8'h20, 8'h01);
      @(posedge clk);
      pin <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chkb(sample_clock_inversion, 1'b1);
      wr(8'h13, 8'h0C);
      repeat (4) @(posedge clk);
      #1;
      chkb(sample_clock_inversion, 1'b0);
      wr(8'h13, 8'h34);
      #1;
      chkb(external_pixel_clock_sel, 1'b1);
      wr(8'h13, 8'h24);
      line;
      chkn(lk, 0);
      chkb(pll_coast, 1'b1);
      pin <= 1'b0;
      wr(8'h13, 8'h14);
      line;
      chkn(ld, 0);
      fork
         line;
         begin
            repeat (10) @(posedge clk);
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
         end
      join
      chkn(ld, 1);
      chkn(w, 4);
      wr(8'h22, 8'h00);
      rd(8'h21, 8'h08);
      line;
      chkn(ld, 1);
      wr(8'h13, 8'h04);
      vs <= 1'b1;
      line;
      chkn(lk, 0);
      chkb(pll_coast, 1'b1);
      vs <= 1'b0;
      line;
      chkb(pll_coast, 1'b1);
      line;
      line;
      chkb(pll_coast, 1'b0);
      results();
   end
endmodule : tb

/* File: cle_top.sv */
// Clamp and lock edge control: register file, pin function mux, clamp events
// Assumes hsync, vsync and the multi-purpose pin are asynchronous pins
`include "cle_defines.svh"
module cle_top
   import cle_pkg::*;
#(
   parameter int          START_W    = 13,
   parameter int unsigned SLOW_CYC   = `CLE_SLOW_UPDATE_CYC,
   parameter int          PRE_LINES  = 4,
   parameter int          POST_LINES = 4
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // Video pins
   input  wire logic       hsync_in,
   input  wire logic       vsync_in,
   input  wire logic       multi_purpose_input_pin,
   // PLL and converter controls
   output logic            pll_lock_strobe,
   output logic            pll_coast,
   output logic            sample_clock_inversion,
   output logic            external_pixel_clock_sel,
   output logic            dc_restore_clamp,
   output logic            auto_black_level_start,
   output logic            offset_dac_load
);
   logic [7:0] misc_reg;
   logic [7:0] misc_next;
   logic [7:0] shi_reg;
   logic [7:0] shi_next;
   logic [7:0] slo_reg;
   logic [7:0] slo_next;
   logic [7:0] wid_reg;
   logic [7:0] wid_next;
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   logic hs_s;
   logic vs_s;
   logic pin_s;
   logic pin;
   cle_pin_fn_e fn;

   logic hs_d_reg;
   logic hs_d_next;
   logic vs_d_reg;
   logic vs_d_next;
   logic pin_d_reg;
   logic pin_d_next;
   logic hs_lead;
   logic hs_trail;
   logic pin_rise;
   logic int_start;
   logic int_clamp;

   logic                pend_reg;
   logic                pend_next;
   logic [31:0]         slow_reg;
   logic [31:0]         slow_next;
   logic [7:0]          line_reg;
   logic [7:0]          line_next;
   logic                post_reg;
   logic                post_next;
   logic                lock_reg;
   logic                lock_next;
   logic                rst_lck_reg;
   logic                rst_lck_next;
   logic                blk_reg;
   logic                blk_next;
   logic                load_reg;
   logic                load_next;
   logic                coast_reg;
   logic                coast_next;
   logic [7:0]          frm_reg;
   logic [7:0]          frm_next;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction : hit

   // Pins cross into the pixel clock domain before anything reads them
   cle_sync u_sync_hs
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in (hsync_in),
      .sync_out (hs_s)
   );
   cle_sync u_sync_vs
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in (vsync_in),
      .sync_out (vs_s)
   );
   cle_sync u_sync_pin
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in (multi_purpose_input_pin),
      .sync_out (pin_s)
   );

   assign pin      = pin_s & ~misc_reg[`CLE_BIT_PIN_DISABLE];
   assign fn       = cle_pin_fn_e'(misc_reg[`CLE_FLD_FUNC_HI:`CLE_FLD_FUNC_LO]);
   assign hs_lead  = hs_s & ~hs_d_reg;
   assign hs_trail = ~hs_s & hs_d_reg;
   assign pin_rise = pin & ~pin_d_reg;

   cle_clamp_gen #(
      .CNT_W (START_W)
   ) u_clamp
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .ce            (ce),
      .trail_edge    (hs_trail),
      .start_pixel   ({shi_reg[`CLE_START_HI_MSB:0], slo_reg}),
      .clamp_width   (wid_reg),
      .start_pulse   (int_start),
      .restore_clamp (int_clamp)
   );

   // Register file
   always_comb
   begin
      misc_next  = misc_reg;
      shi_next   = shi_reg;
      slo_next   = slo_reg;
      wid_next   = wid_reg;
      cfg_next   = cfg_reg;
      rdata_next = 8'h00;
      if (reg_wr)
      begin
         if (hit(reg_addr, `CLE_ADDR_LOCK_PIN))
            misc_next = reg_wdata;
         if (hit(reg_addr, `CLE_ADDR_START_HI))
            shi_next = {3'h0, reg_wdata[`CLE_START_HI_MSB:0]};
         if (hit(reg_addr, `CLE_ADDR_START_LO))
            slo_next = reg_wdata;
         if (hit(reg_addr, `CLE_ADDR_CLAMP_WIDTH))
            wid_next = reg_wdata;
         if (hit(reg_addr, `CLE_ADDR_DAC_CFG))
            cfg_next = reg_wdata;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            `CLE_ADDR_LOCK_PIN:    rdata_next = misc_reg;
            `CLE_ADDR_START_HI:    rdata_next = shi_reg;
            `CLE_ADDR_START_LO:    rdata_next = slo_reg;
            `CLE_ADDR_CLAMP_WIDTH: rdata_next = wid_reg;
            `CLE_ADDR_DAC_CFG:     rdata_next = cfg_reg;
            `CLE_ADDR_STATUS:      rdata_next = {4'h0, pend_reg, coast_reg, pin, hs_s};
            default:               rdata_next = 8'h00;
         endcase
      end
      if (!ce)
      begin
         misc_next  = misc_reg;
         shi_next   = shi_reg;
         slo_next   = slo_reg;
         wid_next   = wid_reg;
         cfg_next   = cfg_reg;
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         misc_reg  <= `CLE_RST_LOCK_PIN;
         shi_reg   <= `CLE_RST_START_HI;
         slo_reg   <= `CLE_RST_START_LO;
         wid_reg   <= `CLE_RST_CLAMP_WIDTH;
         cfg_reg   <= `CLE_RST_DAC_CFG;
         rdata_reg <= 8'h00;
      end
      else
      begin
         misc_reg  <= misc_next;
         shi_reg   <= shi_next;
         slo_reg   <= slo_next;
         wid_reg   <= wid_next;
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // Control outputs
   always_comb
   begin
      logic ext_clamp;
      logic ext_coast;
      logic clamp_evt;
      logic vs_rise;
      logic vs_fall;
      ext_clamp = (fn == CLE_FN_CLAMP);
      ext_coast = (fn == CLE_FN_COAST) & pin;
      vs_rise   = vs_s & ~vs_d_reg;
      vs_fall   = ~vs_s & vs_d_reg;
      clamp_evt = ext_clamp ? pin_rise : int_start;
      hs_d_next  = hs_s;
      vs_d_next  = vs_s;
      pin_d_next = pin;
      line_next  = line_reg;
      post_next  = post_reg;
      frm_next   = frm_reg;
      // No vsync look-ahead: pre-coast predicts from the last frame's line count
      if (vs_rise)
      begin
         post_next = 1'b0;
         line_next = 8'h00;
         frm_next  = line_reg;
      end
      else if (vs_fall)
      begin
         post_next = 1'b1;
         line_next = 8'h00;
      end
      else if (hs_trail && line_reg != 8'hFF)
         line_next = line_reg + 8'h01;
      coast_next = ext_coast | vs_s
                   | (post_reg & (line_reg < 8'(POST_LINES)))
                   | ((frm_reg != 8'h00) & (9'(line_reg) + 9'(PRE_LINES) >= {1'b0, frm_reg}));
      lock_next = ~coast_next & (misc_reg[`CLE_BIT_LOCK_EDGE] ? hs_lead : hs_trail);
      // An external clamp replaces the internal pulse
      rst_lck_next = (ext_clamp ? pin : int_clamp) & cfg_reg[`CLE_BIT_DCR_EN];
      blk_next     = clamp_evt & ~cfg_reg[`CLE_BIT_BLACK_DIS];
      // Written DAC values wait for a clamp; the timer bounds the wait
      pend_next = pend_reg;
      slow_next = slow_reg;
      if (pend_reg)
         slow_next = slow_reg + 32'h1;
      load_next = clamp_evt | (pend_reg & (slow_reg >= SLOW_CYC - 1));
      if (load_next)
      begin
         pend_next = 1'b0;
         slow_next = 32'h0;
      end
      if (reg_wr && hit(reg_addr, `CLE_ADDR_DAC_WRITE))
         pend_next = 1'b1;  // Set wins over the load in the same cycle
      if (!ce)
      begin
         hs_d_next    = hs_d_reg;
         vs_d_next    = vs_d_reg;
         pin_d_next   = pin_d_reg;
         line_next    = line_reg;
         post_next    = post_reg;
         frm_next     = frm_reg;
         coast_next   = coast_reg;
         lock_next    = lock_reg;
         rst_lck_next = rst_lck_reg;
         blk_next     = blk_reg;
         load_next    = load_reg;
         pend_next    = pend_reg;
         slow_next    = slow_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_d_reg    <= 1'b0;
         vs_d_reg    <= 1'b0;
         pin_d_reg   <= 1'b0;
         line_reg    <= 8'h00;
         post_reg    <= 1'b0;
         frm_reg     <= 8'h00;
         coast_reg   <= 1'b0;
         lock_reg    <= 1'b0;
         rst_lck_reg <= 1'b0;
         blk_reg     <= 1'b0;
         load_reg    <= 1'b0;
         pend_reg    <= 1'b0;
         slow_reg    <= 32'h0;
      end
      else
      begin
         hs_d_reg    <= hs_d_next;
         vs_d_reg    <= vs_d_next;
         pin_d_reg   <= pin_d_next;
         line_reg    <= line_next;
         post_reg    <= post_next;
         frm_reg     <= frm_next;
         coast_reg   <= coast_next;
         lock_reg    <= lock_next;
         rst_lck_reg <= rst_lck_next;
         blk_reg     <= blk_next;
         load_reg    <= load_next;
         pend_reg    <= pend_next;
         slow_reg    <= slow_next;
      end
   end

   assign reg_rdata                = rdata_reg;
   assign pll_lock_strobe          = lock_reg;
   assign pll_coast                = coast_reg;
   assign sample_clock_inversion   = (fn == CLE_FN_INVERT) & pin;
   assign external_pixel_clock_sel = (fn == CLE_FN_EXT_PCLK);
   assign dc_restore_clamp         = rst_lck_reg;
   assign auto_black_level_start   = blk_reg;
   assign offset_dac_load          = load_reg;
endmodule : cle_top

/* File: cle_top_monitor.sv */
// Port checker for the clamp and lock edge block
// Assumes one clock domain and attachment to cle_top by the bind below
module cle_top_checker
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       ce,
   // Register port
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Controls
   input wire logic       pll_lock_strobe,
   input wire logic       pll_coast,
   input wire logic       sample_clock_inversion,
   input wire logic       external_pixel_clock_sel,
   input wire logic       dc_restore_clamp,
   input wire logic       auto_black_level_start,
   input wire logic       offset_dac_load
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Clamp high-time counter; widths above 255 cannot come from an 8-bit register
   logic [8:0] hi_cnt_reg;
   logic [8:0] hi_cnt_next;
   always_comb
   begin
      hi_cnt_next = dc_restore_clamp ? hi_cnt_reg + 9'h001 : 9'h000;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hi_cnt_reg <= 9'h000;
      else
         hi_cnt_reg <= hi_cnt_next;
   end
   a_lock_one_cycle: assert property (pll_lock_strobe |=> !pll_lock_strobe)
      else $error("lock strobe longer than one cycle");
   a_black_start_pulse: assert property (auto_black_level_start |=> !auto_black_level_start)
      else $error("black loop start longer than one cycle");
   a_dac_load_pulse: assert property (offset_dac_load |=> !offset_dac_load)
      else $error("offset load longer than one cycle");
   a_rdata_idle_zero: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_pin_fn_exclusive: assert property (sample_clock_inversion |-> !external_pixel_clock_sel)
      else $error("two pin functions at once");
   a_clamp_min_width: assert property ($rose(dc_restore_clamp) |=> dc_restore_clamp)
      else $error("restore clamp of one cycle");
   a_coast_no_lock: assert property ($past(pll_coast) && pll_coast |-> !pll_lock_strobe)
      else $error("lock strobe while coasting");
   a_clamp_max_width: assert property (hi_cnt_reg <= 9'h0FF)
      else $error("restore clamp wider than any width");
endmodule : cle_top_checker

bind cle_top cle_top_checker cle_top_checker_inst
(
   .clk                      (clk),
   .rst_n                    (rst_n),
   .ce                       (ce),
   .reg_rd                   (reg_rd),
   .reg_rdata                (reg_rdata),
   .pll_lock_strobe          (pll_lock_strobe),
   .pll_coast                (pll_coast),
   .sample_clock_inversion   (sample_clock_inversion),
   .external_pixel_clock_sel (external_pixel_clock_sel),
   .dc_restore_clamp         (dc_restore_clamp),
   .auto_black_level_start   (auto_black_level_start),
   .offset_dac_load          (offset_dac_load)
);

/* File: cle_video_src.sv */
// Video source model: one hsync pulse per request, vsync follows a level
// Assumes requests come from the bench on the pixel clock
module cle_video_src
#(
   parameter int SYNC_LEN = 5
)
(
   input  wire logic clk,
   input  wire logic go,
   input  wire logic vs,
   output logic      hsync_in,
   output logic      vsync_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // Leading edge after the request, trailing edge SYNC_LEN cycles later
   always @(posedge clk)
   begin
      if (go)
         cnt <= SYNC_LEN;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   assign hsync_in = (cnt > 0);
   assign vsync_in = vs;
endmodule : cle_video_src
